//--- verilog/asc_regbank.sv
// asc_regbank: converter control, calibration and pin registers on an AXI4-Lite slave.
// assumes one clock, synchronous low reset, registers in byte lane 0 of aligned words.
//
// Operation
// - the serial timeout runs only while control bit 2 is set, and that bit resets to 0.
// - control bit 1 appends a CRC byte over the result and any status byte, resetting to 0.
// - control bit 0 sends a status byte before each result, resetting to 0.
// - mid-supply, temperature and supply monitor selections open all external input switches.
// - a supply monitor selection forces amplifier gain to 1 whatever the gain field holds.
// - the reserved bytes at 0Ah and 0Dh read zero and the host writes only 00h to them.
// - a 16-bit offset trim sits low byte at 0Bh and high byte at 0Ch, both resetting to 0.
// - a 16-bit gain trim sits low byte at 0Eh resetting to 0 and high byte at 0Fh resetting to 40h.
// - pin levels register bits 7:4 set each pin's direction, 0 output and 1 input, resetting to 0.
// - bits 3:0 hold levels, driven on outputs and sampled on inputs, resetting to 0.
// - a pin acts as digital I/O only while its function bit is 1, otherwise direction and level do nothing.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "asc_map.svh"
module asc_regbank (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [2:0] gain_code,
   input wire logic [3:0] pin_in,
   output asc_pkg::asc_ctrl_s ctrl,
   output logic [15:0] offset_trim_value,
   output logic [15:0] gain_trim_value,
   output asc_pkg::asc_pio_s pins
);
   import asc_pkg::*;
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic aw_held, next_aw_held, w_held, next_w_held;
   asc_idx_t aw_idx, next_aw_idx, ar_idx;
   logic [7:0] wbyte, next_wbyte;
   logic wlane, next_wlane, wr_fire;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [7:0] rd_byte;
   logic [7:0] system_control, next_system_control;
   logic [7:0] offset_trim_low, next_offset_trim_low;
   logic [7:0] offset_trim_high, next_offset_trim_high;
   logic [7:0] gain_trim_low, next_gain_trim_low;
   logic [7:0] gain_trim_high, next_gain_trim_high;
   logic [7:0] pin_io_levels, next_pin_io_levels;
   logic [3:0] pin_function_select, next_pin_function_select;
   logic [2:0] next_mon;
   logic [3:0] rd_levels;
   asc_ctrl_s next_ctrl;

   // mapped window is contiguous, so a range test is enough
   function automatic logic idx_mapped(input asc_idx_t idx);
      idx_mapped = (idx >= `ASC_IDX_SYSCTRL) && (idx <= `ASC_IDX_PFUNC);
   endfunction : idx_mapped

   // ----------------------------------------
   // write channel
   // ----------------------------------------
   // address and data are taken in either order; the write happens once both are held
   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_idx = aw_idx;
      next_wbyte = wbyte;
      next_wlane = wlane;
      next_bvalid = bvalid;
      next_bresp = bresp;
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_aw_idx = awaddr[7:2];
      end
      if (wvalid && wready) begin
         next_w_held = 1'b1;
         next_wbyte = wdata[7:0];
         next_wlane = wstrb[0];
      end
      wr_fire = aw_held && w_held && !bvalid;
      if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_fire) begin
         next_bvalid = 1'b1;
         next_bresp = idx_mapped(aw_idx) ? `ASC_RESP_OKAY : `ASC_RESP_DECERR;
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
      end
      // no new write is taken while a response waits, which also bars a second write
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_comb begin
      next_system_control = system_control;
      next_offset_trim_low = offset_trim_low;
      next_offset_trim_high = offset_trim_high;
      next_gain_trim_low = gain_trim_low;
      next_gain_trim_high = gain_trim_high;
      next_pin_io_levels = pin_io_levels;
      next_pin_function_select = pin_function_select;
      // a clear lane-0 strobe leaves the register untouched but still answers okay
      if (wr_fire && wlane) begin
         unique case (aw_idx)
            `ASC_IDX_SYSCTRL: next_system_control = wbyte;
            `ASC_IDX_OFS_LO: next_offset_trim_low = wbyte;
            `ASC_IDX_OFS_HI: next_offset_trim_high = wbyte;
            `ASC_IDX_GAIN_LO: next_gain_trim_low = wbyte;
            `ASC_IDX_GAIN_HI: next_gain_trim_high = wbyte;
            `ASC_IDX_PIO: next_pin_io_levels = wbyte;
            `ASC_IDX_PFUNC: next_pin_function_select = wbyte[3:0];
            default: next_system_control = system_control;
         endcase
      end
   end

   // ----------------------------------------
   // controls to the converter
   // ----------------------------------------
   // decoded from next values so controls and register never disagree
   always_comb begin
      next_mon = next_system_control[`ASC_MON_MSB:`ASC_MON_LSB];
      next_ctrl.timeout_en = next_system_control[`ASC_BIT_TMO];
      next_ctrl.crc_en = next_system_control[`ASC_BIT_CRC];
      next_ctrl.status_prepend_enable = next_system_control[`ASC_BIT_STAT];
      next_ctrl.analog_mux_open = (next_mon == `ASC_MON_MID) || (next_mon == `ASC_MON_TEMP) ||
                                  (next_mon == `ASC_MON_AVDD) || (next_mon == `ASC_MON_DVDD);
      // supply monitors force unity; temperature gain limit is the host's duty
      next_ctrl.pga_gain = ((next_mon == `ASC_MON_AVDD) || (next_mon == `ASC_MON_DVDD)) ?
                           `ASC_GAIN_ONE : gain_code;
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   always_comb begin
      ar_idx = araddr[7:2];
      unique case (ar_idx)
         `ASC_IDX_SYSCTRL: rd_byte = system_control;
         `ASC_IDX_OFS_LO: rd_byte = offset_trim_low;
         `ASC_IDX_OFS_HI: rd_byte = offset_trim_high;
         `ASC_IDX_GAIN_LO: rd_byte = gain_trim_low;
         `ASC_IDX_GAIN_HI: rd_byte = gain_trim_high;
         `ASC_IDX_PIO: rd_byte = {pin_io_levels[7:4], rd_levels};
         `ASC_IDX_PFUNC: rd_byte = {4'h0, pin_function_select};
         default: rd_byte = `ASC_RST_ZERO;
      endcase
   end

   always_comb begin
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rdata = {24'h000000, rd_byte};
         next_rresp = idx_mapped(ar_idx) ? `ASC_RESP_OKAY : `ASC_RESP_DECERR;
      end
      next_arready = !next_rvalid;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // reset loads documented values
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_idx <= 6'h00;
         wbyte <= 8'h00;
         wlane <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `ASC_RESP_OKAY;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `ASC_RESP_OKAY;
         system_control <= `ASC_RST_SYSCTRL;
         offset_trim_low <= `ASC_RST_ZERO;
         offset_trim_high <= `ASC_RST_ZERO;
         gain_trim_low <= `ASC_RST_ZERO;
         gain_trim_high <= `ASC_RST_GAIN_HI;
         pin_io_levels <= `ASC_RST_ZERO;
         pin_function_select <= `ASC_RST_PFUNC;
         ctrl <= '0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_idx <= next_aw_idx;
         wbyte <= next_wbyte;
         wlane <= next_wlane;
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         arready <= next_arready;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
         system_control <= next_system_control;
         offset_trim_low <= next_offset_trim_low;
         offset_trim_high <= next_offset_trim_high;
         gain_trim_low <= next_gain_trim_low;
         gain_trim_high <= next_gain_trim_high;
         pin_io_levels <= next_pin_io_levels;
         pin_function_select <= next_pin_function_select;
         ctrl <= next_ctrl;
      end
   end

   assign offset_trim_value = {offset_trim_high, offset_trim_low};
   assign gain_trim_value = {gain_trim_high, gain_trim_low};

   // pins lag the register by one clock
   asc_pin_bank u_pins (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(pin_in),
      .dir(pin_io_levels[7:4]),
      .level(pin_io_levels[3:0]),
      .func(pin_function_select),
      .pins(pins),
      .rd_levels(rd_levels)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_tmo;
      wr_fire && wlane && aw_idx == `ASC_IDX_SYSCTRL |=> ctrl.timeout_en == $past(wbyte[`ASC_BIT_TMO]) && bvalid;
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout enable not written");
   property p_crc;
      wr_fire && wlane && aw_idx == `ASC_IDX_SYSCTRL |=> ctrl.crc_en == $past(wbyte[`ASC_BIT_CRC]);
   endproperty
   a_crc: assert property (p_crc) else $error("crc enable not written");
   property p_stat;
      wr_fire && wlane && aw_idx == `ASC_IDX_SYSCTRL |=> ctrl.status_prepend_enable == $past(wbyte[`ASC_BIT_STAT]);
   endproperty
   a_stat: assert property (p_stat) else $error("status enable not written");
   property p_mux;
      system_control[7:5] inside {`ASC_MON_MID, `ASC_MON_TEMP, `ASC_MON_AVDD, `ASC_MON_DVDD} |-> ctrl.analog_mux_open;
   endproperty
   a_mux: assert property (p_mux) else $error("switches closed under monitor");
   property p_gain1;
      system_control[7:5] inside {`ASC_MON_AVDD, `ASC_MON_DVDD} |-> ctrl.pga_gain == `ASC_GAIN_ONE;
   endproperty
   a_gain1: assert property (p_gain1) else $error("gain not forced to one");
   property p_rsvd;
      arvalid && arready && (ar_idx == `ASC_IDX_RSVD_A || ar_idx == `ASC_IDX_RSVD_D)
         |=> rvalid && rdata == 32'h00000000 && rresp == `ASC_RESP_OKAY;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved byte read nonzero");
   property p_ofs;
      wr_fire && wlane && aw_idx == `ASC_IDX_OFS_HI |=> offset_trim_value[15:8] == $past(wbyte) [*2];
   endproperty
   a_ofs: assert property (p_ofs) else $error("offset trim high not held");
   property p_gcal;
      wr_fire && wlane && aw_idx == `ASC_IDX_GAIN_LO |=> gain_trim_value[7:0] == $past(wbyte);
   endproperty
   a_gcal: assert property (p_gcal) else $error("gain trim low not written");
   property p_rst;
      $rose(aresetn) |-> gain_trim_value == {`ASC_RST_GAIN_HI, `ASC_RST_ZERO} && offset_trim_value == 16'h0000
         && system_control == `ASC_RST_SYSCTRL && !awready && !arready;
   endproperty
   a_rst: assert property (p_rst) else $error("bank not at reset values");
   c_wr_ctrl: cover property (wr_fire && aw_idx == `ASC_IDX_SYSCTRL);
   c_rd_rsvd: cover property (rvalid && rready && rdata == 32'h00000000);
   c_supply: cover property (ctrl.analog_mux_open && ctrl.pga_gain == `ASC_GAIN_ONE);
endmodule : asc_regbank

//--- verilog/asc_map.svh
// asc_map.svh: offsets, field positions and reset values of the converter register bank.
// assumes byte address = 4 * register index on the word bus.
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH
// ----------------------------------------
// register indexes (byte address is four times)
// ----------------------------------------
`define ASC_IDX_SYSCTRL 6'h09
`define ASC_IDX_RSVD_A 6'h0a
`define ASC_IDX_OFS_LO 6'h0b
`define ASC_IDX_OFS_HI 6'h0c
`define ASC_IDX_RSVD_D 6'h0d
`define ASC_IDX_GAIN_LO 6'h0e
`define ASC_IDX_GAIN_HI 6'h0f
`define ASC_IDX_PIO 6'h10
`define ASC_IDX_PFUNC 6'h11
// ----------------------------------------
// reset values
// ----------------------------------------
`define ASC_RST_SYSCTRL 8'h10
`define ASC_RST_GAIN_HI 8'h40
`define ASC_RST_ZERO 8'h00
`define ASC_RST_PFUNC 4'h0
// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define ASC_BIT_STAT 0
`define ASC_BIT_CRC 1
`define ASC_BIT_TMO 2
`define ASC_MON_MSB 7
`define ASC_MON_LSB 5
`define ASC_MON_MID 3'h1
`define ASC_MON_TEMP 3'h2
`define ASC_MON_AVDD 3'h3
`define ASC_MON_DVDD 3'h4
`define ASC_GAIN_ONE 3'h0
`define ASC_RESP_OKAY 2'h0
`define ASC_RESP_DECERR 2'h3
`endif

//--- verilog/asc_pkg.sv
// asc_pkg: types shared by the register bank and its pin bank.
// assumes asc_map.svh carries every number.
package asc_pkg;
   typedef logic [5:0] asc_idx_t;
   // controls handed to the conversion and analog logic
   typedef struct packed {
      logic timeout_en;
      logic crc_en;
      logic status_prepend_enable;
      logic analog_mux_open;
      logic [2:0] pga_gain;
   } asc_ctrl_s;
   // four general-purpose pins, enable low while driving
   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe_n;
   } asc_pio_s;
endpackage : asc_pkg

//--- verilog/asc_pin_bank.sv
// asc_pin_bank: four general-purpose pins with direction, level and function select.
// assumes raw pin levels arrive asynchronously; control bits come from the same clock.
`timescale 1ns/1ns
module asc_pin_bank (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] pin_in,
   input wire logic [3:0] dir,
   input wire logic [3:0] level,
   input wire logic [3:0] func,
   output asc_pkg::asc_pio_s pins,
   output logic [3:0] rd_levels
);
   import asc_pkg::*;
   logic [3:0] sync1;
   logic [3:0] sync2;
   // ----------------------------------------
   // per-pin logic
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_pin
         logic next_out;
         logic next_oe_n;
         always_comb begin
            next_out = level[i];
            next_oe_n = !(func[i] && !dir[i]);
         end
         // two flops before any reader of the pin
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sync1[i] <= 1'b0;
               sync2[i] <= 1'b0;
               pins.out[i] <= 1'b0;
               pins.oe_n[i] <= 1'b1;
            end else begin
               sync1[i] <= pin_in[i];
               sync2[i] <= sync1[i];
               pins.out[i] <= next_out;
               pins.oe_n[i] <= next_oe_n;
            end
         end
         assign rd_levels[i] = (func[i] && dir[i]) ? sync2[i] : level[i];
      end
   endgenerate
   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_dir_drive;
      1'b1 |=> pins.oe_n == ~($past(func) & ~$past(dir));
   endproperty
   a_dir_drive: assert property (p_dir_drive) else $error("pin enable does not follow direction");
   property p_level_out;
      1'b1 |=> pins.out == $past(level);
   endproperty
   a_level_out: assert property (p_level_out) else $error("pin level does not follow stored level");
   property p_analog_idle;
      (func == 4'h0) [*2] |-> pins.oe_n == 4'hf;
   endproperty
   a_analog_idle: assert property (p_analog_idle) else $error("analog pin is driven");
   property p_in_read;
      (func == 4'hf && dir == 4'hf) |-> rd_levels == $past(pin_in, 2);
   endproperty
   a_in_read: assert property (p_in_read) else $error("input pin read is not the sampled level");
   c_pin_out: cover property (!pins.oe_n[0] && pins.out[0]);
endmodule : asc_pin_bank

//--- test/asc_pin_world.sv
// asc_pin_world: the board around the four general-purpose pins.
// assumes the bench sets the level that outside parts put on released pins.
`timescale 1ns/1ns
module asc_pin_world (
   input wire logic [3:0] ext_level,
   input asc_pkg::asc_pio_s pins,
   output logic [3:0] pin_in
);
   import asc_pkg::*;
   // ----------------------------------------
   // wire level
   // ----------------------------------------
   // a driven pin shows the block's level, a released one what the board puts on it
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_in[i] = pins.oe_n[i] ? ext_level[i] : pins.out[i];
      end
   end
endmodule : asc_pin_world

//--- test/tb.sv
// tb: self-checking bench for the converter register bank on AXI4-Lite.
// assumes asc_pkg, asc_regbank and asc_pin_world are compiled before it.
`timescale 1ns/1ns
module tb;
   import asc_pkg::*;
   logic aclk = 1'b0;
   logic aresetn;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h1;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [2:0] gain_code = 3'h0;
   logic [3:0] ext_level = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [3:0] pin_in;
   asc_ctrl_s ctrl;
   asc_pio_s pins;
   logic [15:0] offset_trim_value, gain_trim_value;
   logic [31:0] seed = 32'h35;
   int mdl [0:63];
   int err_total = 0;
   int cmp_count = 0;
   int trim_idx [4] = '{11, 12, 14, 15};
   int odd_idx [4] = '{10, 13, 18, 63};

   // free-running clock, 10 ns
   always #5 aclk = ~aclk;

   asc_regbank asc_regbank_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .gain_code(gain_code),
      .pin_in(pin_in), .ctrl(ctrl), .offset_trim_value(offset_trim_value),
      .gain_trim_value(gain_trim_value), .pins(pins));
   asc_pin_world asc_pin_world_inst (.ext_level(ext_level), .pins(pins), .pin_in(pin_in));

   // ----------------------------------------
   // model and compare
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic bit mapped(int idx);
      return idx >= 9 && idx <= 17;
   endfunction : mapped

   // input pins read back the board level, every other bit the stored one
   function automatic logic [31:0] exp_rd(int idx);
      logic [3:0] inp;
      inp = mdl[17][3:0] & mdl[16][7:4];
      if (!mapped(idx)) return 32'h0;
      if (idx == 16) return {24'h0, mdl[16][7:4], (mdl[16][3:0] & ~inp) | (ext_level & inp)};
      return 32'(mdl[idx]);
   endfunction : exp_rd

   task automatic chk_out(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : chk_out

   task automatic chk_ports();
      logic [7:0] s;
      logic [3:0] drv;
      s = mdl[9][7:0];
      drv = mdl[17][3:0] & ~mdl[16][7:4];
      chk_out(32'(ctrl), {25'h0, s[2], s[1], s[0], s[7:5] inside {[3'h1:3'h4]},
         (s[7:5] == 3'h3 || s[7:5] == 3'h4) ? 3'h0 : gain_code}, "ctrl");
      chk_out(32'(offset_trim_value), {16'h0, mdl[12][7:0], mdl[11][7:0]}, "offset");
      chk_out(32'(gain_trim_value), {16'h0, mdl[15][7:0], mdl[14][7:0]}, "gain");
      chk_out(32'(pins.oe_n), {28'h0, ~drv}, "oe_n");
      chk_out(32'(pins.out & drv), 32'(mdl[16][3:0] & drv), "out");
   endtask : chk_ports

   // ----------------------------------------
   // bus master
   // ----------------------------------------
   // ready is looked at on the falling edge, where it is settled for the coming rising edge
   task automatic wr(input int idx, input logic [7:0] d);
      int n;
      logic a_t, w_t, bv;
      logic [1:0] br;
      logic [31:0] r;
      n = 0;
      bv = 1'b0;
      br = 2'h0;
      r = rnd();
      awaddr <= 8'(idx * 4);
      wdata <= {r[31:8], d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bv && n < 40) begin
         @(negedge aclk);
         a_t = awready === 1'b1;
         w_t = wready === 1'b1;
         bv = bvalid === 1'b1;
         br = bresp;
         @(posedge aclk);
         if (a_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      chk_out(32'({bv, br}), {29'h0, 1'b1, mapped(idx) ? 2'h0 : 2'h3}, "write answer");
      // reserved bytes keep their zero
      // a clear lane-0 strobe stores nothing but still answers okay
      if (mapped(idx) && idx != 10 && idx != 13 && wstrb[0]) mdl[idx] = (idx == 17) ? d & 8'h0f : d;
      // idle edge so the next request does not reassign the same signals in this step
      @(posedge aclk);
   endtask : wr

   task automatic rd_chk(input int idx);
      int n;
      logic a_t, rv;
      logic [31:0] d;
      logic [1:0] r;
      n = 0;
      rv = 1'b0;
      araddr <= 8'(idx * 4);
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rv && n < 40) begin
         @(negedge aclk);
         a_t = arready === 1'b1;
         rv = rvalid === 1'b1;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (a_t) arvalid <= 1'b0;
         n++;
      end
      rready <= 1'b0;
      chk_out(32'({rv, r}), {29'h0, 1'b1, mapped(idx) ? 2'h0 : 2'h3}, "read answer");
      chk_out(d, exp_rd(idx), "read data");
      @(posedge aclk);
   endtask : rd_chk

   task automatic do_reset();
      aresetn <= 1'b0;
      for (int i = 0; i < 64; i++) mdl[i] = 0;
      mdl[9] = 'h10;
      mdl[15] = 'h40;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : do_reset

   task automatic note(input string name);
      $display("test %s done: %0d checks, %0d mismatches", name, cmp_count, err_total);
   endtask : note

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      logic [31:0] r;
      do_reset();
      for (int i = 8; i <= 18; i++) begin
         rd_chk(i);
      end
      chk_ports();
      note("reset values");
      // every monitor code, with random low control bits
      for (int c = 0; c < 8; c++) begin
         r = rnd();
         // gain of 4 or less while temperature is selected, also just before it is left
         gain_code <= (c == 2 || c == 3) ? 3'(r[9:8] % 2'h3) : r[10:8];
         wr(9, {3'(c), r[4:0]});
         chk_ports();
         rd_chk(9);
      end
      note("control");
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         wstrb <= (k == 5) ? 4'he : 4'h1; // one write with lane 0 off
         wr(trim_idx[k % 4], r[7:0]);
         rd_chk(trim_idx[k % 4]);
         chk_ports();
      end
      note("trims");
      // host writes only zero to reserved bytes
      for (int j = 0; j < 4; j++) begin
         r = rnd();
         wr(odd_idx[j], (j < 2) ? 8'h00 : r[7:0]);
         rd_chk(odd_idx[j]);
      end
      note("reserved and unmapped");
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         // first pass makes every pin a digital input so the sampled path is read
         wr(17, {4'h0, (k == 0) ? 4'hf : r[3:0]});
         wr(16, (k == 0) ? {4'hf, r[11:8]} : r[15:8]);
         ext_level <= r[19:16];
         repeat (3) @(posedge aclk);
         rd_chk(16);
         rd_chk(17);
         chk_ports();
      end
      note("pins");
      do_reset();
      for (int i = 9; i <= 17; i++) begin
         rd_chk(i);
      end
      chk_ports();
      note("second reset");
      end_of_test();
   end

   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge aclk);
      err_total++;
      $display("Error at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule : tb
